/* hw/pbps_debounce.sv */
// Purpose: button debouncer; pressed rises after N consecutive low cycles
// Assumes: raw is synchronous; active low button
// Notes: any high cycle or disable restarts the count
`timescale 1ns/1ps
module pbps_debounce
   import pbps_pkg::*;
#(
   parameter int unsigned CYCLES = DEBOUNCE_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   pbps_debounce_if.filter dbi
);
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic next_pressed;

   // count low cycles, restart on release
   always_comb begin
      next_cnt = cnt;
      next_pressed = dbi.pressed;
      if (!dbi.enable || dbi.raw) begin
         next_cnt = '0;
         next_pressed = 1'b0;
      end else if (!dbi.pressed) begin
         if (cnt == CNT_W'(CYCLES - 1)) begin
            next_pressed = 1'b1;
         end else begin
            next_cnt = cnt + CNT_W'(1);
         end
      end
   end

   // register count and press flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         dbi.pressed <= 1'b0;
      end else begin
         cnt <= next_cnt;
         dbi.pressed <= next_pressed;
      end
   end

   AST_DEBOUNCE_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      (dbi.raw || !dbi.enable) |=> !dbi.pressed && cnt == '0)
      else $error("debounce did not restart on release");
   AST_DEBOUNCE_TIME: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(dbi.pressed) |-> $past(cnt) == CNT_W'(CYCLES - 1))
      else $error("press reported before full debounce count");
endmodule

/* hw/pbps_debounce_if.sv */
// Purpose: carries the raw button level and the debounced press
// Assumes: button level is synchronous to the clock
// Notes: enable low holds the debouncer cleared
`timescale 1ns/1ps
interface pbps_debounce_if;
   logic raw;
   logic enable;
   logic pressed;
   modport filter (input raw, input enable, output pressed);
   modport user (output raw, output enable, input pressed);
endinterface

/* hw/pbps_pkg.sv */
// Purpose: shared constants of the push-button power sequencer
// Assumes: 25 MHz system clock
// Notes: delays are given in ms and turned into clock cycle counts here
package pbps_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int DEBOUNCE_MS = 50;
   localparam int EXT_LEAD_MS = 1;
   localparam int PG_DELAY_MS = 20;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int EXT_LEAD_CYC = EXT_LEAD_MS * (CLK_HZ / 1000);
   localparam int PG_DELAY_CYC = PG_DELAY_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 32;
   localparam int SEL_W = 3;
   // defaults restored at reset and on undervoltage lockout
   localparam logic [SEL_W-1:0] BUCK_SEQ_DEFAULT = 3'h4;
   localparam logic [SEL_W-1:0] LINEAR_SEQ_DEFAULT = 3'h7;
   localparam logic MASK_DEFAULT = 1'h1;
   localparam logic DEEP_REQ_DEFAULT = 1'h0;
   localparam logic SAVED_DEFAULT = 1'h0;
   typedef enum logic [2:0] {
      PBPS_OFF, PBPS_DEBOUNCE, PBPS_EXT_LEAD, PBPS_RAMP_LIN2, PBPS_RAMP_BUCKS,
      PBPS_RUN, PBPS_DEEP
   } pbps_state_t;
endpackage

/* hw/pbps_sequencer.sv */
// Purpose: push-button start, rail ordering, sleep and deep sleep control
// Assumes: all inputs synchronous to CLK; SW_WRITE loads all control fields
// Notes: rail enables are registered from the next state, so they move with state
`timescale 1ns/1ps
module pbps_sequencer
   import pbps_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned EXT_LEAD_CYCLES = EXT_LEAD_CYC,
   parameter int unsigned PG_DELAY_CYCLES = PG_DELAY_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic POWER_BUTTON_IN,
   input wire logic HOLD_ON_IN,
   input wire logic CHARGER_PRESENT,
   input wire logic UVLO,
   input wire logic BUCK_THREE_ENABLE_PIN,
   input wire logic LINEAR_TWO_GOOD,
   input wire logic BUCK_ONE_GOOD,
   input wire logic SW_WRITE,
   input wire logic [SEL_W-1:0] SW_BUCK_SEQUENCE_SELECT,
   input wire logic [SEL_W-1:0] SW_LINEAR_SEQUENCE_SELECT,
   input wire logic SW_BUCK_THREE_PIN_MASK,
   input wire logic SW_DEEP_SLEEP_REQUEST,
   input wire logic SW_MEMORY_SAVED_FLAG,
   output logic [SEL_W-1:0] BUCK_SEQUENCE_SELECT,
   output logic [SEL_W-1:0] LINEAR_SEQUENCE_SELECT,
   output logic BUCK_THREE_PIN_MASK,
   output logic DEEP_SLEEP_REQUEST,
   output logic MEMORY_SAVED_FLAG,
   output logic SYSTEM_RAIL_ON,
   output logic EXTERNAL_REGULATOR_ENABLE,
   output logic BUCK_ONE_ON,
   output logic BUCK_TWO_ON,
   output logic BUCK_THREE_ON,
   output logic LINEAR_REG_ONE_ON,
   output logic LINEAR_REG_TWO_ON,
   output logic KEYPRESS_OUT,
   output logic POWER_GOOD_RESET_OUT
);
   pbps_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic hold_prev;
   logic [SEL_W-1:0] next_bsel, next_lsel;
   logic next_mask, next_ds_req, next_saved;
   logic next_sys, next_ext, next_b1, next_b2, next_b3, next_l1, next_l2, next_pg;
   logic powered, released;
   pbps_debounce_if dbi ();
   // debouncer is alive in every state except PBPS_OFF, debounce and deep sleep included
   assign dbi.raw = POWER_BUTTON_IN;
   assign dbi.enable = (state != PBPS_OFF);
   pbps_debounce #(
      .CYCLES(DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk(CLK),
      .rst_n(RST_N),
      .dbi(dbi.filter)
   );
   // rails up from external enable onward, deep sleep excluded
   assign powered = (state == PBPS_EXT_LEAD) || (state == PBPS_RAMP_LIN2) ||
                    (state == PBPS_RAMP_BUCKS) || (state == PBPS_RUN);
   assign released = POWER_BUTTON_IN && !HOLD_ON_IN;

   // next state, delay counter and control fields
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_bsel = BUCK_SEQUENCE_SELECT;
      next_lsel = LINEAR_SEQUENCE_SELECT;
      next_mask = BUCK_THREE_PIN_MASK;
      next_ds_req = DEEP_SLEEP_REQUEST;
      next_saved = MEMORY_SAVED_FLAG;
      case (state)
         PBPS_OFF: begin
            next_cnt = '0;
            if (!POWER_BUTTON_IN) begin
               next_state = PBPS_DEBOUNCE;
            end else if (CHARGER_PRESENT && HOLD_ON_IN && !hold_prev) begin
               next_state = PBPS_EXT_LEAD;
            end
         end
         PBPS_DEBOUNCE: begin
            if (dbi.pressed || (CHARGER_PRESENT && HOLD_ON_IN)) begin
               next_state = PBPS_EXT_LEAD;
            end else if (released) begin
               next_state = PBPS_OFF;
            end
         end
         PBPS_EXT_LEAD: begin
            if (cnt == CNT_W'(EXT_LEAD_CYCLES - 1)) begin
               next_state = PBPS_RAMP_LIN2;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + CNT_W'(1);
            end
         end
         PBPS_RAMP_LIN2: begin
            if (LINEAR_TWO_GOOD) begin
               next_state = PBPS_RAMP_BUCKS;
            end
         end
         PBPS_RAMP_BUCKS: begin
            if (!BUCK_ONE_GOOD) begin
               next_cnt = '0;
            end else if (cnt == CNT_W'(PG_DELAY_CYCLES - 1)) begin
               next_state = PBPS_RUN;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + CNT_W'(1);
            end
         end
         PBPS_RUN: begin
            if (DEEP_SLEEP_REQUEST) begin
               next_state = PBPS_DEEP;
            end
         end
         PBPS_DEEP: begin
            next_cnt = '0;
            if (dbi.pressed) begin
               next_state = PBPS_EXT_LEAD;
               next_ds_req = 1'b0;
            end
         end
         default: next_state = PBPS_OFF;
      endcase
      // losing the button without hold-on drops everything, except in deep sleep
      if (powered && released) begin
         next_state = PBPS_OFF;
         next_cnt = '0;
      end
      // software write after the hardware clear so a set wins
      if (SW_WRITE) begin
         next_bsel = SW_BUCK_SEQUENCE_SELECT;
         next_lsel = SW_LINEAR_SEQUENCE_SELECT;
         next_mask = SW_BUCK_THREE_PIN_MASK;
         next_ds_req = SW_DEEP_SLEEP_REQUEST;
         next_saved = SW_MEMORY_SAVED_FLAG;
      end
      // undervoltage lockout: factory defaults and a cold start
      if (UVLO) begin
         next_state = PBPS_OFF;
         next_cnt = '0;
         next_bsel = BUCK_SEQ_DEFAULT;
         next_lsel = LINEAR_SEQ_DEFAULT;
         next_mask = MASK_DEFAULT;
         next_ds_req = DEEP_REQ_DEFAULT;
         next_saved = SAVED_DEFAULT;
      end
   end

   // rail enables derived from the next state
   always_comb begin
      next_sys = (next_state != PBPS_OFF) || CHARGER_PRESENT;
      next_ext = 1'b0;
      next_b1 = 1'b0;
      next_b2 = 1'b0;
      next_b3 = 1'b0;
      next_l1 = 1'b0;
      next_l2 = 1'b0;
      next_pg = 1'b0;
      case (next_state)
         PBPS_EXT_LEAD: next_ext = 1'b1;
         PBPS_RAMP_LIN2: begin
            next_ext = 1'b1;
            next_l2 = 1'b1;
            next_b3 = next_mask || BUCK_THREE_ENABLE_PIN;
            next_l1 = BUCK_THREE_ENABLE_PIN;
         end
         PBPS_RAMP_BUCKS, PBPS_RUN: begin
            next_ext = 1'b1;
            next_l2 = 1'b1;
            next_b1 = 1'b1;
            next_b2 = 1'b1;
            next_b3 = next_mask || BUCK_THREE_ENABLE_PIN;
            next_l1 = BUCK_THREE_ENABLE_PIN;
            next_pg = (next_state == PBPS_RUN);
         end
         PBPS_DEEP: next_b2 = 1'b1;
         default: next_ext = 1'b0;
      endcase
   end

   // register state, fields and every output
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= PBPS_OFF;
         cnt <= '0;
         hold_prev <= 1'b0;
         BUCK_SEQUENCE_SELECT <= BUCK_SEQ_DEFAULT;
         LINEAR_SEQUENCE_SELECT <= LINEAR_SEQ_DEFAULT;
         BUCK_THREE_PIN_MASK <= MASK_DEFAULT;
         DEEP_SLEEP_REQUEST <= DEEP_REQ_DEFAULT;
         MEMORY_SAVED_FLAG <= SAVED_DEFAULT;
         SYSTEM_RAIL_ON <= 1'b0;
         EXTERNAL_REGULATOR_ENABLE <= 1'b0;
         BUCK_ONE_ON <= 1'b0;
         BUCK_TWO_ON <= 1'b0;
         BUCK_THREE_ON <= 1'b0;
         LINEAR_REG_ONE_ON <= 1'b0;
         LINEAR_REG_TWO_ON <= 1'b0;
         KEYPRESS_OUT <= 1'b1;
         POWER_GOOD_RESET_OUT <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         hold_prev <= HOLD_ON_IN;
         BUCK_SEQUENCE_SELECT <= next_bsel;
         LINEAR_SEQUENCE_SELECT <= next_lsel;
         BUCK_THREE_PIN_MASK <= next_mask;
         DEEP_SLEEP_REQUEST <= next_ds_req;
         MEMORY_SAVED_FLAG <= next_saved;
         SYSTEM_RAIL_ON <= next_sys;
         EXTERNAL_REGULATOR_ENABLE <= next_ext;
         BUCK_ONE_ON <= next_b1;
         BUCK_TWO_ON <= next_b2;
         BUCK_THREE_ON <= next_b3;
         LINEAR_REG_ONE_ON <= next_l1;
         LINEAR_REG_TWO_ON <= next_l2;
         KEYPRESS_OUT <= !dbi.pressed;
         POWER_GOOD_RESET_OUT <= next_pg;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   AST_OFF_RAILS: assert property (
      (state == PBPS_OFF) && $past(state) == PBPS_OFF |-> !BUCK_ONE_ON && !BUCK_TWO_ON &&
      !LINEAR_REG_TWO_ON && !EXTERNAL_REGULATOR_ENABLE && !POWER_GOOD_RESET_OUT)
      else $error("rail on while shut down");
   AST_RELEASE_OFF: assert property (
      (state == PBPS_RUN) && POWER_BUTTON_IN && !HOLD_ON_IN |=> state == PBPS_OFF)
      else $error("no shutdown on button release");
   AST_CHARGER_START: assert property (
      (state == PBPS_OFF) && POWER_BUTTON_IN && CHARGER_PRESENT && HOLD_ON_IN &&
      !hold_prev && !UVLO |=> state == PBPS_EXT_LEAD)
      else $error("hold-on did not start with charger present");
   AST_DEFAULT_SELECT: assert property (
      UVLO |=> BUCK_SEQUENCE_SELECT == 3'h4 && LINEAR_SEQUENCE_SELECT == 3'h7)
      else $error("sequence selects not at defaults");
   AST_KEYPRESS: assert property (
      dbi.pressed |=> !KEYPRESS_OUT)
      else $error("keypress not shown after debounce");
   AST_EXT_LEAD: assert property (
      (state == PBPS_RAMP_LIN2) && $past(state) != PBPS_RAMP_LIN2 |->
      $past(state) == PBPS_EXT_LEAD && $past(cnt) == CNT_W'(EXT_LEAD_CYCLES - 1))
      else $error("lin2 ramp before external lead time");
   AST_BUCKS_AFTER_LIN2: assert property (
      (state == PBPS_RAMP_LIN2) && LINEAR_TWO_GOOD && !released && !UVLO |=>
      (state == PBPS_RAMP_BUCKS) ##1 BUCK_ONE_ON && BUCK_TWO_ON)
      else $error("bucks not ramped after lin2 good");
   AST_PG_DELAY: assert property (
      $rose(POWER_GOOD_RESET_OUT) |-> $past(state) == PBPS_RAMP_BUCKS &&
      $past(cnt) == CNT_W'(PG_DELAY_CYCLES - 1) && $past(BUCK_ONE_GOOD))
      else $error("power good released off the delay");
   AST_BUCK3_CTRL: assert property (
      (state == PBPS_RUN) && $past(state) == PBPS_RUN |->
      BUCK_THREE_ON == (BUCK_THREE_PIN_MASK || $past(BUCK_THREE_ENABLE_PIN)) &&
      LINEAR_REG_ONE_ON == $past(BUCK_THREE_ENABLE_PIN) && BUCK_ONE_ON && BUCK_TWO_ON)
      else $error("buck three or lin1 not following mask and pin");
   AST_DEEP_RAILS: assert property (
      (state == PBPS_DEEP) && $past(state) == PBPS_DEEP |-> BUCK_TWO_ON && !BUCK_ONE_ON &&
      !BUCK_THREE_ON && !LINEAR_REG_ONE_ON && !LINEAR_REG_TWO_ON && !POWER_GOOD_RESET_OUT)
      else $error("wrong rails in deep sleep");
   AST_DEEP_WAKE: assert property (
      (state == PBPS_DEEP) && dbi.pressed && !UVLO && !SW_WRITE |=>
      !DEEP_SLEEP_REQUEST && state == PBPS_EXT_LEAD)
      else $error("no wake from deep sleep on press");
   AST_UVLO_DEFAULTS: assert property (
      UVLO |=> state == PBPS_OFF && !MEMORY_SAVED_FLAG && BUCK_THREE_PIN_MASK &&
      !DEEP_SLEEP_REQUEST)
      else $error("undervoltage did not restore defaults");
endmodule

/* tb/pbps_host_model.sv */
// Purpose: host processor and hold-on pull model for the sequencer bench
// Assumes: hold_en, hold_go and sleep_req are bench levels
// Notes: answers the keypress indication one edge later
`timescale 1ns/1ps
module pbps_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic keypress_n,
   input wire logic hold_en,
   input wire logic hold_go,
   input wire logic sleep_req,
   output logic hold_on,
   output logic pin
);
   logic next_hold_on;
   logic next_pin;
   // hold-on rises on a seen keypress, so it is up before the user lets go
   always_comb begin
      next_hold_on = hold_en & (hold_on | ~keypress_n | hold_go);
      next_pin = sleep_req ? 1'h0 : (~keypress_n | pin);
   end
   // host pins change just after the edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_on <= 1'h0;
         pin <= 1'h0;
      end else begin
         hold_on <= next_hold_on;
         pin <= next_pin;
      end
   end
endmodule

/* tb/pbps_sequencer_bench.sv */
// Purpose: self-checking bench of the push-button power sequencer
// Assumes: short delay parameters; rail good inputs follow rail enables
// Notes: outputs are sampled on the falling edge
`timescale 1ns/1ps
module pbps_sequencer_bench;
   import pbps_pkg::*;
   localparam int DB = 8;
   localparam int EL = 4;
   localparam int PG = 6;
   logic CLK = 0, RST_N = 0, btn = 1, chg = 0, uvlo = 0, sw_wr = 0;
   logic [2:0] sw_bsel = 3'h4, sw_lsel = 3'h7;
   logic sw_mask = 0, sw_req = 0, sw_flag = 0, hold_en = 0, hold_go = 0, sleep_req = 0;
   logic lin2_good = 0, b1_good = 0, hold_on, pin;
   logic [2:0] bsel, lsel;
   logic mask, req, flag, system_rail, ext, b1, b2, b3, l1, l2, kp, pg;
   logic [7:0] rails;
   int fails = 0, compares = 0, cycles = 0, n;
   assign rails = {ext, b1, b2, b3, l1, l2, kp, pg};
   always #20 CLK = ~CLK;
   pbps_sequencer #(.DEBOUNCE_CYCLES(DB), .EXT_LEAD_CYCLES(EL), .PG_DELAY_CYCLES(PG)) dut (
      .CLK(CLK), .RST_N(RST_N), .POWER_BUTTON_IN(btn), .HOLD_ON_IN(hold_on),
      .CHARGER_PRESENT(chg), .UVLO(uvlo), .BUCK_THREE_ENABLE_PIN(pin),
      .LINEAR_TWO_GOOD(lin2_good), .BUCK_ONE_GOOD(b1_good), .SW_WRITE(sw_wr),
      .SW_BUCK_SEQUENCE_SELECT(sw_bsel), .SW_LINEAR_SEQUENCE_SELECT(sw_lsel),
      .SW_BUCK_THREE_PIN_MASK(sw_mask), .SW_DEEP_SLEEP_REQUEST(sw_req),
      .SW_MEMORY_SAVED_FLAG(sw_flag), .BUCK_SEQUENCE_SELECT(bsel),
      .LINEAR_SEQUENCE_SELECT(lsel), .BUCK_THREE_PIN_MASK(mask), .DEEP_SLEEP_REQUEST(req),
      .MEMORY_SAVED_FLAG(flag), .SYSTEM_RAIL_ON(system_rail), .EXTERNAL_REGULATOR_ENABLE(ext),
      .BUCK_ONE_ON(b1), .BUCK_TWO_ON(b2), .BUCK_THREE_ON(b3), .LINEAR_REG_ONE_ON(l1),
      .LINEAR_REG_TWO_ON(l2), .KEYPRESS_OUT(kp), .POWER_GOOD_RESET_OUT(pg));
   pbps_host_model host (.clk(CLK), .rst_n(RST_N), .keypress_n(kp), .hold_en(hold_en),
      .hold_go(hold_go), .sleep_req(sleep_req), .hold_on(hold_on), .pin(pin));
   // rail good comparators answer one edge after the enable
   always @(posedge CLK) begin
      lin2_good <= l2;
      b1_good <= b1;
   end
   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_vec({7'h00, got}, {7'h00, exp}, what);
   endtask
   // wait under a bound until the masked rails show the value
   task automatic wait_vec(input logic [7:0] m, input logic [7:0] v, output int cnt);
      cnt = 0;
      while ((rails & m) !== v && cnt < 300) begin
         @(negedge CLK);
         cnt++;
      end
      chk_vec(rails & m, v, "awaited rails");
   endtask
   task automatic sw(input logic mk, input logic rq, input logic fl);
      @(posedge CLK);
      sw_wr <= 1'h1;
      sw_mask <= mk;
      sw_req <= rq;
      sw_flag <= fl;
      @(posedge CLK);
      sw_wr <= 1'h0;
      repeat (3) @(negedge CLK);
   endtask
   task automatic drive_btn(input logic v, input int wait_n);
      @(posedge CLK);
      btn <= v;
      repeat (wait_n) @(negedge CLK);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // cut a hang short
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("wrong value at %0t: run too long", $time);
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge CLK);
      RST_N <= 1'h1;
      @(negedge CLK);
      chk_vec(rails, 8'h02, "reset rails");
      chk_bit(system_rail, 1'h0, "system rail off");
      chk_vec({2'h0, bsel, lsel}, {2'h0, 3'h4, 3'h7}, "sequence selects");
      chk_vec({5'h00, mask, req, flag}, 8'h04, "control fields");
      $display("test reset done");
      drive_btn(1'h0, DB - 3);
      drive_btn(1'h1, DB + 4);
      chk_vec(rails, 8'h02, "short press ignored");
      $display("test short press done");
      hold_en <= 1'h1;
      drive_btn(1'h0, 0);
      wait_vec(8'h02, 8'h00, n);
      chk_bit(n >= DB, 1'h1, "debounce length");
      wait_vec(8'h80, 8'h80, n);
      chk_vec(rails & 8'h54, 8'h00, "nothing before external enable");
      wait_vec(8'h14, 8'h14, n);
      chk_bit(n >= EL, 1'h1, "external lead time");
      wait_vec(8'h60, 8'h60, n);
      drive_btn(1'h1, 0);
      wait_vec(8'h01, 8'h01, n);
      chk_bit(n > PG, 1'h1, "power good delay");
      wait_vec(8'h02, 8'h02, n);
      chk_vec(rails, 8'hFF, "all rails up");
      $display("test power up done");
      sw(1'h0, 1'h0, 1'h0);
      sleep_req <= 1'h1;
      repeat (4) @(negedge CLK);
      chk_vec(rails, 8'hE7, "sleep rails");
      sleep_req <= 1'h0;
      repeat (3) @(negedge CLK);
      chk_vec(rails, 8'hE7, "sleep held by pin");
      drive_btn(1'h0, 0);
      wait_vec(8'h18, 8'h18, n);
      drive_btn(1'h1, 4);
      chk_vec(rails, 8'hFF, "awake rails");
      $display("test sleep done");
      sw(1'h0, 1'h0, 1'h1);
      sw(1'h0, 1'h1, 1'h1);
      repeat (2) @(negedge CLK);
      chk_vec(rails, 8'h22, "deep sleep rails");
      drive_btn(1'h0, 0);
      wait_vec(8'h02, 8'h00, n);
      repeat (2) @(negedge CLK);
      chk_bit(req, 1'h0, "deep request cleared");
      chk_bit(flag, 1'h1, "saved flag kept");
      drive_btn(1'h1, 0);
      wait_vec(8'h01, 8'h01, n);
      repeat (3) @(negedge CLK);
      chk_vec(rails, 8'hFF, "deep wake rails");
      sw(1'h0, 1'h0, 1'h0);
      chk_bit(flag, 1'h0, "saved flag cleared");
      $display("test deep sleep done");
      hold_en <= 1'h0;
      repeat (4) @(negedge CLK);
      chk_vec(rails, 8'h02, "shut down");
      chk_bit(system_rail, 1'h0, "system rail off");
      @(posedge CLK);
      sw_bsel <= 3'h1;
      sw_lsel <= 3'h2;
      sw(1'h0, 1'h0, 1'h1);
      chk_vec({2'h0, bsel, lsel}, {2'h0, 3'h1, 3'h2}, "written selects");
      @(posedge CLK);
      uvlo <= 1'h1;
      @(posedge CLK);
      uvlo <= 1'h0;
      repeat (3) @(negedge CLK);
      chk_vec({5'h00, mask, req, flag}, 8'h04, "lockout defaults");
      chk_vec({2'h0, bsel, lsel}, {2'h0, 3'h4, 3'h7}, "lockout selects");
      $display("test lockout done");
      @(posedge CLK);
      chg <= 1'h1;
      repeat (3) @(negedge CLK);
      chk_bit(system_rail, 1'h1, "charger system rail");
      chk_vec(rails, 8'h02, "converters wait");
      hold_en <= 1'h1;
      hold_go <= 1'h1;
      wait_vec(8'h80, 8'h80, n);
      wait_vec(8'h01, 8'h01, n);
      chk_bit(kp, 1'h1, "no keypress");
      hold_en <= 1'h0;
      hold_go <= 1'h0;
      repeat (4) @(negedge CLK);
      chk_vec(rails, 8'h02, "charger shut down");
      $display("test charger done");
      tally_and_finish();
   end
endmodule
